/* verilog/dtc_top.sv */
// Dual timer/counter unit with shared control and mode registers
// Operation
// - Timer function ticks once per 12 clocks, or 6 with fast option.
// - Counter function counts falling edges on the unit's count pin.
// - Count pin sampled each clock; high then low sample means an edge.
// - New count visible at end of cycle after the detecting cycle.
// - Counter select bit clear picks timer, set picks pin counting.
// - Mode 00 is 13-bit, 01 is 16-bit cascade, 10 is 8-bit reload.
// - Reload mode refills low byte from high byte on each overflow.
// - Modes 00 to 10 equal for both units; mode 11 differs.
// - Unit 1 in mode 11 stops and holds its count.
// - Unit 0 mode 11: low byte normal, high byte timer under unit 1 run.
// - Gate clear counts on run; gate set also needs interrupt pin high.
// - Run bit zero disables, one enables the unit.
// - Overflow sets flag; software or vector acknowledge clears it.
// - Interrupt type zero is low level, one is falling edge.
// - Interrupt flag set on event; software or service acknowledge clears.
// - 13-bit count uses high byte and low five bits of low byte.
// - Overflow means rollover from all ones to all zeros.
// - Setting the run bit leaves count registers alone.
// - Reload leaves the high byte unchanged.
`timescale 1ns/100ps
module dtc_top
  import dtc_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_reset,
  input wire dtc_sfr_req_s i_sfr,
  input wire dtc_vec_ack_s i_vec_ack,
  input wire logic i_fast_clocking_option,
  input wire logic i_unit0_count_pin,
  input wire logic i_unit1_count_pin,
  input wire logic i_ext_irq_a_pin,
  input wire logic i_ext_irq_b_pin,
  output logic [7:0] o_sfr_rdata,
  output logic [7:0] o_timer_control
);

  dtc_state_s state_ff;
  dtc_state_s nxt_state;

  logic u0_fall;
  logic u1_fall;
  logic xa_fall;
  logic xb_fall;
  logic xa_level;
  logic xb_level;

  logic [3:0] presc_div;
  logic tick;
  dtc_mode_e u0_mode;
  dtc_mode_e u1_mode;
  logic u0_gate;
  logic u1_gate;
  logic u0_counter;
  logic u1_counter;
  logic u0_ev;
  logic u1_ev;
  logic th0_ev;
  logic u0_ovf;
  logic u1_ovf;
  logic wr_ctrl;
  logic wr_mode;
  logic wr_tl0;
  logic wr_tl1;
  logic wr_th0;
  logic wr_th1;
  logic [16:0] u0_step;
  logic [16:0] u1_step;
  logic [7:0] ctrl_v;

  dtc_pin_edge u_unit0_pin (
    .i_clock(i_clock),
    .i_reset(i_reset),
    .i_pin(i_unit0_count_pin),
    .o_fall(u0_fall),
    .o_level()
  );

  dtc_pin_edge u_unit1_pin (
    .i_clock(i_clock),
    .i_reset(i_reset),
    .i_pin(i_unit1_count_pin),
    .o_fall(u1_fall),
    .o_level()
  );

  dtc_pin_edge u_ext_a_pin (
    .i_clock(i_clock),
    .i_reset(i_reset),
    .i_pin(i_ext_irq_a_pin),
    .o_fall(xa_fall),
    .o_level(xa_level)
  );

  dtc_pin_edge u_ext_b_pin (
    .i_clock(i_clock),
    .i_reset(i_reset),
    .i_pin(i_ext_irq_b_pin),
    .o_fall(xb_fall),
    .o_level(xb_level)
  );

  // One count step for modes 00, 01 and 10; returns {overflow, high, low}
  function automatic logic [16:0] dtc_step(input dtc_mode_e m, input logic [7:0] lo,
                                           input logic [7:0] hi);
    logic [7:0] nlo;
    logic [7:0] nhi;
    logic ovf;
    nlo = lo;
    nhi = hi;
    ovf = 1'b0;
    case (m)
      DTC_MODE_13BIT: begin
        // Upper low-byte bits are left as they are
        nlo[MODE0_LOW_BITS-1:0] = lo[MODE0_LOW_BITS-1:0] + MODE0_LOW_STEP;
        if (lo[MODE0_LOW_BITS-1:0] == MODE0_LOW_FULL) begin
          nhi = hi + BYTE_STEP;
          ovf = (hi == BYTE_FULL);
        end
      end
      DTC_MODE_16BIT: begin
        nlo = lo + BYTE_STEP;
        if (lo == BYTE_FULL) begin
          nhi = hi + BYTE_STEP;
          ovf = (hi == BYTE_FULL);
        end
      end
      DTC_MODE_RELOAD: begin
        if (lo == BYTE_FULL) begin
          nlo = hi;
          ovf = 1'b1;
        end else begin
          nlo = lo + BYTE_STEP;
        end
      end
      default: begin
        nlo = lo;
      end
    endcase
    return {ovf, nhi, nlo};
  endfunction

  always_comb begin
    nxt_state = state_ff;

    wr_ctrl = 1'b0;
    wr_mode = 1'b0;
    wr_tl0 = 1'b0;
    wr_tl1 = 1'b0;
    wr_th0 = 1'b0;
    wr_th1 = 1'b0;
    if (i_sfr.wr_en) begin
      if (i_sfr.addr == ADDR_TIMER_CONTROL) begin
        wr_ctrl = 1'b1;
      end else if (i_sfr.addr == ADDR_TIMER_MODE_CONFIG) begin
        wr_mode = 1'b1;
      end else if (i_sfr.addr == ADDR_UNIT0_COUNT_LOW) begin
        wr_tl0 = 1'b1;
      end else if (i_sfr.addr == ADDR_UNIT1_COUNT_LOW) begin
        wr_tl1 = 1'b1;
      end else if (i_sfr.addr == ADDR_UNIT0_COUNT_HIGH) begin
        wr_th0 = 1'b1;
      end else if (i_sfr.addr == ADDR_UNIT1_COUNT_HIGH) begin
        wr_th1 = 1'b1;
      end
    end

    // Prescaler; compare with >= so a live switch of the option cannot overrun
    presc_div = i_fast_clocking_option ? CLOCKS_PER_TICK_FAST : CLOCKS_PER_TICK_STD;
    tick = (state_ff.presc >= (presc_div - PRESC_STEP));
    nxt_state.presc = tick ? PRESC_ZERO : state_ff.presc + PRESC_STEP;

    u0_mode = dtc_mode_e'(state_ff.mode[MODE_UNIT0_LSB+MODE_FIELD_HIGH_OFS -:2]);
    u1_mode = dtc_mode_e'(state_ff.mode[MODE_UNIT1_LSB+MODE_FIELD_HIGH_OFS -:2]);
    u0_gate = state_ff.mode[MODE_UNIT0_LSB+MODE_GATE_OFS];
    u1_gate = state_ff.mode[MODE_UNIT1_LSB+MODE_GATE_OFS];
    u0_counter = state_ff.mode[MODE_UNIT0_LSB+MODE_COUNTER_SELECT_OFS];
    u1_counter = state_ff.mode[MODE_UNIT1_LSB+MODE_COUNTER_SELECT_OFS];

    // Count source and enable per unit
    u0_ev = (u0_counter ? u0_fall : tick)
            & state_ff.ctrl[CTRL_UNIT0_RUN_BIT]
            & (~u0_gate | i_ext_irq_a_pin);
    u1_ev = (u1_counter ? u1_fall : tick)
            & state_ff.ctrl[CTRL_UNIT1_RUN_BIT]
            & (~u1_gate | i_ext_irq_b_pin);
    // Split high byte: timer only, run by unit 1's run bit
    th0_ev = tick & state_ff.ctrl[CTRL_UNIT1_RUN_BIT];

    u0_step = dtc_step(u0_mode, state_ff.tl0, state_ff.th0);
    u1_step = dtc_step(u1_mode, state_ff.tl1, state_ff.th1);
    u0_ovf = 1'b0;
    u1_ovf = 1'b0;

    if (u0_mode == DTC_MODE_SPLIT) begin
      if (u0_ev) begin
        nxt_state.tl0 = state_ff.tl0 + BYTE_STEP;
        u0_ovf = (state_ff.tl0 == BYTE_FULL);
      end
      if (th0_ev) begin
        nxt_state.th0 = state_ff.th0 + BYTE_STEP;
        u1_ovf = (state_ff.th0 == BYTE_FULL);
      end
    end else if (u0_ev) begin
      nxt_state.tl0 = u0_step[7:0];
      nxt_state.th0 = u0_step[15:8];
      u0_ovf = u0_step[16];
    end

    // Unit 1 mode 11 holds; its flag belongs to the split high byte while unit 0 is in mode 11
    if (u1_mode != DTC_MODE_SPLIT && u1_ev) begin
      nxt_state.tl1 = u1_step[7:0];
      nxt_state.th1 = u1_step[15:8];
      if (u0_mode != DTC_MODE_SPLIT) begin
        u1_ovf = u1_step[16];
      end
    end

    // Software writes override the same-cycle increment
    if (wr_tl0) begin
      nxt_state.tl0 = i_sfr.wdata;
    end
    if (wr_th0) begin
      nxt_state.th0 = i_sfr.wdata;
    end
    if (wr_tl1) begin
      nxt_state.tl1 = i_sfr.wdata;
    end
    if (wr_th1) begin
      nxt_state.th1 = i_sfr.wdata;
    end
    if (wr_mode) begin
      nxt_state.mode = i_sfr.wdata;
    end

    // Control: write, then acknowledge clears, then hardware sets win
    ctrl_v = wr_ctrl ? i_sfr.wdata : state_ff.ctrl;
    if (i_vec_ack.unit0) begin
      ctrl_v[CTRL_UNIT0_OVERFLOW_FLAG] = 1'b0;
    end
    if (i_vec_ack.unit1) begin
      ctrl_v[CTRL_UNIT1_OVERFLOW_FLAG] = 1'b0;
    end
    if (i_vec_ack.ext_a) begin
      ctrl_v[CTRL_EXT_IRQ_A_FLAG] = 1'b0;
    end
    if (i_vec_ack.ext_b) begin
      ctrl_v[CTRL_EXT_IRQ_B_FLAG] = 1'b0;
    end
    if (u0_ovf) begin
      ctrl_v[CTRL_UNIT0_OVERFLOW_FLAG] = 1'b1;
    end
    if (u1_ovf) begin
      ctrl_v[CTRL_UNIT1_OVERFLOW_FLAG] = 1'b1;
    end
    // A held-low level pin re-sets its flag after every clear
    if (state_ff.ctrl[CTRL_EXT_IRQ_A_TYPE] ? xa_fall : ~xa_level) begin
      ctrl_v[CTRL_EXT_IRQ_A_FLAG] = 1'b1;
    end
    if (state_ff.ctrl[CTRL_EXT_IRQ_B_TYPE] ? xb_fall : ~xb_level) begin
      ctrl_v[CTRL_EXT_IRQ_B_FLAG] = 1'b1;
    end
    nxt_state.ctrl = ctrl_v;

    // Read data: value before this cycle's update, answered next cycle
    if (i_sfr.addr == ADDR_TIMER_CONTROL) begin
      nxt_state.rdata = state_ff.ctrl;
    end else if (i_sfr.addr == ADDR_TIMER_MODE_CONFIG) begin
      nxt_state.rdata = state_ff.mode;
    end else if (i_sfr.addr == ADDR_UNIT0_COUNT_LOW) begin
      nxt_state.rdata = state_ff.tl0;
    end else if (i_sfr.addr == ADDR_UNIT1_COUNT_LOW) begin
      nxt_state.rdata = state_ff.tl1;
    end else if (i_sfr.addr == ADDR_UNIT0_COUNT_HIGH) begin
      nxt_state.rdata = state_ff.th0;
    end else if (i_sfr.addr == ADDR_UNIT1_COUNT_HIGH) begin
      nxt_state.rdata = state_ff.th1;
    end else begin
      nxt_state.rdata = UNMAPPED_READ_VALUE;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      state_ff <= DTC_STATE_RST;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign o_sfr_rdata = state_ff.rdata;
  assign o_timer_control = state_ff.ctrl;

  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_reset);

  sequence s_u0_pin_fall;
    i_unit0_count_pin ##1 !i_unit0_count_pin;
  endsequence

  sequence s_u0_pin_count;
    u0_fall && u0_counter && state_ff.ctrl[CTRL_UNIT0_RUN_BIT] && !u0_gate
      && u0_mode == DTC_MODE_16BIT && !wr_tl0 && !wr_th0;
  endsequence

  AST_PIN_EDGE_DETECT: assert property (s_u0_pin_fall |=> ##1 u0_fall)
    else $error("count pin fall not detected two cycles on");

  AST_PIN_COUNT_STEP: assert property (
    s_u0_pin_count |=> state_ff.tl0 == $past(state_ff.tl0) + BYTE_STEP)
    else $error("pin edge did not advance unit 0 low byte");

  // A live switch to the fast option may legally cut the gap short
  AST_TICK_SPACING: assert property (
    tick && !i_fast_clocking_option |=> !tick [*5] ##1 (!tick || i_fast_clocking_option) [*6]
      ##1 (tick || i_fast_clocking_option))
    else $error("timer tick spacing wrong in standard rate");

  AST_RELOAD: assert property (
    u0_mode == DTC_MODE_RELOAD && u0_ev && state_ff.tl0 == BYTE_FULL && !wr_tl0 && !wr_th0
    |=> state_ff.tl0 == $past(state_ff.th0) && $stable(state_ff.th0))
    else $error("reload did not copy high byte into low byte");

  AST_UNIT1_HOLD: assert property (
    u1_mode == DTC_MODE_SPLIT && !wr_tl1 && !wr_th1
    |=> $stable(state_ff.tl1) && $stable(state_ff.th1))
    else $error("unit 1 moved while stopped");

  AST_GATE_BLOCK: assert property (
    u0_gate && !i_ext_irq_a_pin && !wr_tl0 |=> $stable(state_ff.tl0))
    else $error("gated unit 0 counted with interrupt pin low");

  AST_RUN_OFF: assert property (
    !state_ff.ctrl[CTRL_UNIT0_RUN_BIT] && u0_mode != DTC_MODE_SPLIT && !wr_tl0 && !wr_th0
    |=> $stable(state_ff.tl0) && $stable(state_ff.th0))
    else $error("unit 0 counted while disabled");

  AST_OVERFLOW_FLAG: assert property (
    u0_ovf |=> state_ff.ctrl[CTRL_UNIT0_OVERFLOW_FLAG] && (state_ff.tl0 == BYTE_ZERO
      || $past(u0_mode) == DTC_MODE_13BIT && ~|state_ff.tl0[MODE0_LOW_BITS-1:0])
      || $past(wr_tl0) || $past(u0_mode) == DTC_MODE_RELOAD)
    else $error("unit 0 overflow flag not set on rollover");

  AST_EXT_EDGE_FLAG: assert property (
    state_ff.ctrl[CTRL_EXT_IRQ_A_TYPE] && xa_fall |=> state_ff.ctrl[CTRL_EXT_IRQ_A_FLAG])
    else $error("edge interrupt flag a not set");

  AST_SPLIT_HIGH: assert property (
    u0_mode == DTC_MODE_SPLIT && th0_ev && state_ff.th0 == BYTE_FULL && !wr_th0
    |=> state_ff.th0 == BYTE_ZERO && state_ff.ctrl[CTRL_UNIT1_OVERFLOW_FLAG])
    else $error("split high byte overflow missed unit 1 flag");

  AST_WRITE_WINS: assert property (wr_tl0 |=> state_ff.tl0 == $past(i_sfr.wdata))
    else $error("count write lost to increment");

endmodule

/* verilog/dtc_pkg.sv */
// Shared constants, register map and carrier types of the dual timer/counter unit
package dtc_pkg;

  // Register addresses on the special function register port
  localparam logic [7:0] ADDR_TIMER_CONTROL = 8'h88;
  localparam logic [7:0] ADDR_TIMER_MODE_CONFIG = 8'h89;
  localparam logic [7:0] ADDR_UNIT0_COUNT_LOW = 8'h8A;
  localparam logic [7:0] ADDR_UNIT1_COUNT_LOW = 8'h8B;
  localparam logic [7:0] ADDR_UNIT0_COUNT_HIGH = 8'h8C;
  localparam logic [7:0] ADDR_UNIT1_COUNT_HIGH = 8'h8D;

  localparam logic [7:0] REG_RESET_VALUE = 8'h00;
  localparam logic [7:0] UNMAPPED_READ_VALUE = 8'h00;

  // Field positions in timer_control
  localparam int CTRL_UNIT1_OVERFLOW_FLAG = 7;
  localparam int CTRL_UNIT1_RUN_BIT = 6;
  localparam int CTRL_UNIT0_OVERFLOW_FLAG = 5;
  localparam int CTRL_UNIT0_RUN_BIT = 4;
  localparam int CTRL_EXT_IRQ_B_FLAG = 3;
  localparam int CTRL_EXT_IRQ_B_TYPE = 2;
  localparam int CTRL_EXT_IRQ_A_FLAG = 1;
  localparam int CTRL_EXT_IRQ_A_TYPE = 0;

  // Field positions in timer_mode_config; unit 1 owns the upper nibble
  localparam int MODE_UNIT0_LSB = 0;
  localparam int MODE_UNIT1_LSB = 4;
  localparam int MODE_GATE_OFS = 3;
  localparam int MODE_COUNTER_SELECT_OFS = 2;
  localparam int MODE_FIELD_HIGH_OFS = 1;
  localparam int MODE_FIELD_LOW_OFS = 0;

  // Count widths and limits
  localparam int MODE0_LOW_BITS = 5;
  localparam logic [4:0] MODE0_LOW_FULL = 5'h1F;
  localparam logic [4:0] MODE0_LOW_STEP = 5'h01;
  localparam logic [7:0] BYTE_FULL = 8'hFF;
  localparam logic [7:0] BYTE_STEP = 8'h01;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  // System clocks per timer tick
  localparam logic [3:0] CLOCKS_PER_TICK_STD = 4'hC;
  localparam logic [3:0] CLOCKS_PER_TICK_FAST = 4'h6;
  localparam logic [3:0] PRESC_STEP = 4'h1;
  localparam logic [3:0] PRESC_ZERO = 4'h0;

  typedef enum logic [1:0] {
    DTC_MODE_13BIT,
    DTC_MODE_16BIT,
    DTC_MODE_RELOAD,
    DTC_MODE_SPLIT
  } dtc_mode_e;

  typedef struct packed {
    logic wr_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } dtc_sfr_req_s;

  typedef struct packed {
    logic unit1;
    logic unit0;
    logic ext_b;
    logic ext_a;
  } dtc_vec_ack_s;

  typedef struct packed {
    logic samp;
    logic prev;
    logic fall;
  } dtc_pin_s;

  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] mode;
    logic [7:0] tl0;
    logic [7:0] tl1;
    logic [7:0] th0;
    logic [7:0] th1;
    logic [3:0] presc;
    logic [7:0] rdata;
  } dtc_state_s;

  // Pins idle high; a low reset sample would fake a level interrupt after reset
  localparam dtc_pin_s DTC_PIN_RST = '{samp: 1'b1, prev: 1'b1, fall: 1'b0};
  localparam dtc_state_s DTC_STATE_RST = '0;

endpackage

/* verilog/dtc_pin_edge.sv */
// Pin sampler with falling-edge detect for count and interrupt pins
`timescale 1ns/100ps
module dtc_pin_edge
  import dtc_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic i_pin,
  output logic o_fall,
  output logic o_level
);

  dtc_pin_s state_ff;
  dtc_pin_s nxt_state;

  always_comb begin
    nxt_state = state_ff;
    nxt_state.samp = i_pin;
    nxt_state.prev = state_ff.samp;
    // High sample followed by low sample; registered so the count lands a cycle later
    nxt_state.fall = state_ff.prev & ~state_ff.samp;
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      state_ff <= DTC_PIN_RST;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign o_fall = state_ff.fall;
  assign o_level = state_ff.samp;

endmodule

/* verification/dtc_pin_model.sv */
// Far-side model: count pins and external interrupt pins
`timescale 1ns/100ps
module dtc_pin_model
(
  input wire logic i_clock,
  output logic [3:0] o_pins
);
  // Order: ext_irq_b, ext_irq_a, unit1 count, unit0 count; pulled up, idle high
  logic [3:0] pins_ff = 4'hF;

  assign o_pins = pins_ff;

  // Each level held one full machine cycle so the sampler cannot miss it
  task automatic pulse(input int idx);
    @(posedge i_clock);
    pins_ff[idx] <= 1'b0;
    repeat (12) @(posedge i_clock);
    pins_ff[idx] <= 1'b1;
    repeat (12) @(posedge i_clock);
  endtask

  task automatic level(input int idx, input logic val);
    @(posedge i_clock);
    pins_ff[idx] <= val;
  endtask
endmodule

/* verification/dual_timer_counter_unit_bench.sv */
// Self-checking bench of the dual timer/counter unit
`timescale 1ns/100ps
module dual_timer_counter_unit_bench
  import dtc_pkg::*;
;
  logic i_clock = 1'b0;
  logic i_reset = 1'b1;
  dtc_sfr_req_s sfr = '0;
  logic [3:0] vec = 4'h0;
  logic fast = 1'b0;
  logic [3:0] pins;
  logic [7:0] rdata;
  logic [7:0] tctl;
  int mismatches = 0;
  int check_count = 0;

  always #5 i_clock = ~i_clock;

  dtc_pin_model i_pins (.i_clock(i_clock), .o_pins(pins));

  dtc_top i_dut (
    .i_clock(i_clock),
    .i_reset(i_reset),
    .i_sfr(sfr),
    .i_vec_ack(vec),
    .i_fast_clocking_option(fast),
    .i_unit0_count_pin(pins[0]),
    .i_unit1_count_pin(pins[1]),
    .i_ext_irq_a_pin(pins[2]),
    .i_ext_irq_b_pin(pins[3]),
    .o_sfr_rdata(rdata),
    .o_timer_control(tctl)
  );

  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clock);
    sfr <= dtc_sfr_req_s'{1'b1, a, d};
    @(posedge i_clock);
    sfr.wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_clock);
    sfr.addr <= a;
    @(posedge i_clock);
    #1 d = rdata;
  endtask

  task automatic ack(input logic [3:0] bits);
    @(posedge i_clock);
    vec <= bits;
    @(posedge i_clock);
    vec <= 4'h0;
    #1;
  endtask

  task automatic regs_scn();
    logic [7:0] d;
    for (int a = 0; a < 6; a++) begin
      rd(8'(ADDR_TIMER_CONTROL + a), d);
      chk("reset value", REG_RESET_VALUE, d);
    end
    wr(8'h8E, 8'hFF);
    rd(8'h8E, d);
    chk("unmapped read", UNMAPPED_READ_VALUE, d);
    wr(ADDR_TIMER_MODE_CONFIG, 8'hA5);
    rd(ADDR_TIMER_MODE_CONFIG, d);
    chk("mode readback", 8'hA5, d);
  endtask

  // Tick count of a run window is exact, so the result does not depend on tick phase
  task automatic tmr(input int u, input logic [1:0] m, input logic f, input logic [7:0] tl,
                     input logic [7:0] th, input logic [7:0] etl, input logic [7:0] eth);
    logic [7:0] d;
    @(posedge i_clock);
    fast <= f;
    wr(ADDR_TIMER_CONTROL, 8'h00);
    wr(ADDR_TIMER_MODE_CONFIG, 8'({6'h00, m} << (4 * u)));
    wr(8'(ADDR_UNIT0_COUNT_LOW + u), tl);
    wr(8'(ADDR_UNIT0_COUNT_HIGH + u), th);
    wr(ADDR_TIMER_CONTROL, 8'(8'h10 << (2 * u)));
    repeat ((f ? 6 : 12) * 3 - 4) @(posedge i_clock);
    #1 chk("overflow flag", 8'h01, {7'h00, tctl[5 + 2 * u]});
    ack(u ? 4'b1000 : 4'b0100);
    chk("flag after ack", 8'h00, {7'h00, tctl[5 + 2 * u]});
    wr(ADDR_TIMER_CONTROL, 8'h00);
    rd(8'(ADDR_UNIT0_COUNT_LOW + u), d);
    chk("count low", etl, d & ((m == 2'b00) ? 8'h1F : 8'hFF));
    rd(8'(ADDR_UNIT0_COUNT_HIGH + u), d);
    chk("count high", eth, d);
  endtask

  task automatic cnt(input int u, input logic g, input logic lo, input logic [7:0] exp);
    logic [7:0] d;
    wr(ADDR_TIMER_CONTROL, 8'h00);
    wr(ADDR_TIMER_MODE_CONFIG, 8'({4'h0, g, 3'b101} << (4 * u)));
    wr(8'(ADDR_UNIT0_COUNT_LOW + u), 8'h00);
    if (lo) begin
      i_pins.level(2 + u, 1'b0);
    end
    wr(ADDR_TIMER_CONTROL, 8'(8'h10 << (2 * u)));
    repeat (3) i_pins.pulse(u);
    wr(ADDR_TIMER_CONTROL, 8'h00);
    i_pins.level(2 + u, 1'b1);
    rd(8'(ADDR_UNIT0_COUNT_LOW + u), d);
    chk("event count", exp, d);
  endtask

  task automatic irq(input int i);
    wr(ADDR_TIMER_CONTROL, 8'(8'h01 << (2 * i)));
    i_pins.pulse(2 + i);
    #1 chk("edge irq flag", 8'h01, {7'h00, tctl[2 * i + 1]});
    ack(i ? 4'b0010 : 4'b0001);
    chk("irq flag after ack", 8'h00, {7'h00, tctl[2 * i + 1]});
    wr(ADDR_TIMER_CONTROL, 8'h00);
    i_pins.level(2 + i, 1'b0);
    repeat (3) @(posedge i_clock);
    #1 chk("level irq flag", 8'h01, {7'h00, tctl[2 * i + 1]});
    wr(ADDR_TIMER_CONTROL, 8'h00);
    repeat (2) @(posedge i_clock);
    #1 chk("level irq reasserts", 8'h01, {7'h00, tctl[2 * i + 1]});
    i_pins.level(2 + i, 1'b1);
    repeat (4) @(posedge i_clock);
    wr(ADDR_TIMER_CONTROL, 8'h00);
    #1 chk("irq flag cleared", 8'h00, {7'h00, tctl[2 * i + 1]});
  endtask

  task automatic split_scn();
    logic [7:0] d;
    @(posedge i_clock);
    fast <= 1'b0;
    wr(ADDR_TIMER_CONTROL, 8'h00);
    wr(ADDR_TIMER_MODE_CONFIG, 8'h33);
    wr(ADDR_UNIT0_COUNT_LOW, 8'h00);
    wr(ADDR_UNIT1_COUNT_LOW, 8'h10);
    wr(ADDR_UNIT0_COUNT_HIGH, 8'hFE);
    wr(ADDR_TIMER_CONTROL, 8'h40);
    repeat (12 * 3 - 2) @(posedge i_clock);
    #1 chk("unit1 flag in split", 8'h01, {7'h00, tctl[7]});
    wr(ADDR_TIMER_CONTROL, 8'h00);
    rd(ADDR_UNIT0_COUNT_HIGH, d);
    chk("split high byte", 8'h01, d);
    rd(ADDR_UNIT0_COUNT_LOW, d);
    chk("split low byte idle", 8'h00, d);
    rd(ADDR_UNIT1_COUNT_LOW, d);
    chk("unit1 held", 8'h10, d);
  endtask

  // Hang guard well above the full run length
  initial begin
    repeat (100000) @(posedge i_clock);
    mismatches++;
    summarize();
  end

  initial begin
    repeat (3) @(posedge i_clock);
    i_reset <= 1'b0;
    regs_scn();
    for (int u = 0; u < 2; u++) begin
      tmr(u, 2'b00, u[0], 8'hFE, 8'hFF, 8'h01, 8'h00);
      tmr(u, 2'b01, u[0], 8'hFE, 8'hFF, 8'h01, 8'h00);
      tmr(u, 2'b10, u[0], 8'hFE, 8'hF0, 8'hF1, 8'hF0);
    end
    cnt(0, 1'b0, 1'b0, 8'h03);
    cnt(1, 1'b1, 1'b0, 8'h03);
    cnt(0, 1'b1, 1'b1, 8'h00);
    irq(0);
    irq(1);
    split_scn();
    summarize();
  end
endmodule
